// *** core/acc_pkg.sv ***
// Constants and types shared by the converter control block.
// How it works
// - Speed field picks divisor 1080/810/540/270
// - Channel field drives analog input selector
// - Completion clears start, sets flag, loads result
// - Writing one starts; writing zero ignored
// - No new start while start/flag set
// - Flag raises interrupt when all enables set
// - Enable bit powers converter; wait 5us first
// - Result is unsigned Vin*256/Vdd code
// - No conversions during power-down mode
package acc_pkg;
    localparam logic [11:0] ACC_OFS_CTRL = 12'h314;
    localparam logic [11:0] ACC_OFS_RESULT = 12'h318;
    localparam logic [11:0] ACC_OFS_IRQ_STAT = 12'h400;
    localparam logic [11:0] ACC_OFS_IRQ_MASK = 12'h404;
    localparam logic [11:0] ACC_OFS_IRQ_EN = 12'h408;
    localparam int ACC_CTRL_IDX = 197;
    localparam int ACC_RESULT_IDX = 198;
    localparam int ACC_BIT_ENABLE = 7;
    localparam int ACC_BIT_SPEED_HI = 6;
    localparam int ACC_BIT_SPEED_LO = 5;
    localparam int ACC_BIT_DONE = 4;
    localparam int ACC_BIT_START = 3;
    localparam int ACC_BIT_CHAN_HI = 2;
    localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
    localparam logic [7:0] ACC_RESULT_RESET = 8'h00;
    localparam logic [10:0] ACC_DIV_0 = 11'd1080;
    localparam logic [10:0] ACC_DIV_1 = 11'd810;
    localparam logic [10:0] ACC_DIV_2 = 11'd540;
    localparam logic [10:0] ACC_DIV_3 = 11'd270;
    localparam int ACC_CLK_MHZ = 50;
    localparam int ACC_WARMUP_NS = 5000;
    localparam int ACC_WARMUP_CYC = (ACC_WARMUP_NS * ACC_CLK_MHZ + 999) / 1000;
    localparam int ACC_IRQ_BIT_DONE = 0;
    localparam int ACC_IRQ_BIT_EARLY = 1;
    typedef enum logic [1:0] {ACC_IDLE, ACC_CONV} acc_state_t;

    function automatic logic [10:0] acc_divisor(input logic [1:0] sel);
        unique case (sel)
            2'b00: acc_divisor = ACC_DIV_0;
            2'b01: acc_divisor = ACC_DIV_1;
            2'b10: acc_divisor = ACC_DIV_2;
            2'b11: acc_divisor = ACC_DIV_3;
        endcase
    endfunction
endpackage

// *** core/acc_sync.sv ***
// Two-flop synchroniser for pin-side levels.
`timescale 1ns/10ps
module acc_sync #(parameter int W = 8) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            q <= '0;
        end else begin
            s1_r <= d;
            q <= s1_r;
        end
    end
endmodule // acc_sync

// *** core/acc_timer.sv ***
// Conversion timer: counts the selected divisor of system clocks.
`timescale 1ns/10ps
module acc_timer
    import acc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [1:0] speed_sel,
    output logic done
);
    logic [10:0] cnt_r;
    logic [10:0] cnt_nxt;
    logic [10:0] lim;

    always_comb begin
        lim = acc_divisor(speed_sel);
        cnt_nxt = '0;
        done = 1'b0;
        if (run) begin
            if (cnt_r == lim - 11'd1) begin
                done = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 11'd1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // acc_timer

// *** core/acc_top.sv ***
// Converter control: APB registers, start/complete sequencing, interrupt.
`timescale 1ns/10ps
module acc_top
    import acc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] sar_code,
    input wire logic power_down,
    output logic converter_power_on,
    output logic [2:0] analog_input_selector,
    output logic sample_hold,
    output logic conv_irq
);
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] result_r, result_nxt;
    logic [1:0] stat_r, stat_nxt;
    logic [1:0] mask_r, mask_nxt;
    logic [2:0] ien_r, ien_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic irq_r, irq_nxt, hold_r, hold_nxt;
    logic [12:0] warm_r, warm_nxt;
    acc_state_t st_r, st_nxt;
    logic [7:0] code_s;
    logic pd_s;
    logic tim_done;
    logic wr, rd, hit;
    logic start_req;
    logic finish;

    acc_sync #(.W(8)) u_code_sync (.pclk(pclk), .presetn(presetn), .d(sar_code), .q(code_s));
    acc_sync #(.W(1)) u_pd_sync (.pclk(pclk), .presetn(presetn), .d(power_down), .q(pd_s));

    acc_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .run(st_r == ACC_CONV),
        .speed_sel(ctrl_r[ACC_BIT_SPEED_HI:ACC_BIT_SPEED_LO]),
        .done(tim_done)
    );

    // Slave answers in the first access cycle, so pready is held high.
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign hit = (paddr == ACC_OFS_CTRL) || (paddr == ACC_OFS_RESULT) || (paddr == ACC_OFS_IRQ_STAT)
        || (paddr == ACC_OFS_IRQ_MASK) || (paddr == ACC_OFS_IRQ_EN);
    assign start_req = wr && paddr == ACC_OFS_CTRL && pwdata[ACC_BIT_START]
        && !ctrl_r[ACC_BIT_START] && !ctrl_r[ACC_BIT_DONE] && pwdata[ACC_BIT_ENABLE] && !pd_s;
    // A conversion is abandoned if the enable drops or power-down arrives mid-way.
    assign finish = st_r == ACC_CONV && tim_done && ctrl_r[ACC_BIT_ENABLE] && !pd_s;

    always_comb begin
        ctrl_nxt = ctrl_r;
        result_nxt = result_r;
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        ien_nxt = ien_r;
        st_nxt = st_r;
        warm_nxt = warm_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        if (!ctrl_r[ACC_BIT_ENABLE]) begin
            warm_nxt = '0;
        end else if (warm_r < 13'(ACC_WARMUP_CYC)) begin
            warm_nxt = warm_r + 13'd1;
        end
        if (rd) begin
            prdata_nxt = '0;
            unique case (paddr)
                ACC_OFS_CTRL: prdata_nxt[7:0] = ctrl_r;
                ACC_OFS_RESULT: prdata_nxt[7:0] = result_r;
                ACC_OFS_IRQ_STAT: prdata_nxt[1:0] = stat_r;
                ACC_OFS_IRQ_MASK: prdata_nxt[1:0] = mask_r;
                ACC_OFS_IRQ_EN: prdata_nxt[2:0] = ien_r;
                default: prdata_nxt = '0;
            endcase
        end
        if (psel && !penable && !hit) begin
            pslverr_nxt = 1'b1;
        end
        if (wr) begin
            unique case (paddr)
                ACC_OFS_CTRL: begin
                    ctrl_nxt[ACC_BIT_ENABLE:ACC_BIT_SPEED_LO] = pwdata[7:5];
                    ctrl_nxt[ACC_BIT_CHAN_HI:0] = pwdata[2:0];
                    if (!pwdata[ACC_BIT_DONE]) begin
                        ctrl_nxt[ACC_BIT_DONE] = 1'b0;
                    end
                    if (start_req) begin
                        ctrl_nxt[ACC_BIT_START] = 1'b1;
                        st_nxt = ACC_CONV;
                        if (warm_r < 13'(ACC_WARMUP_CYC)) begin
                            stat_nxt[ACC_IRQ_BIT_EARLY] = 1'b1;
                        end
                    end
                end
                ACC_OFS_IRQ_STAT: stat_nxt = stat_nxt & ~pwdata[1:0];
                ACC_OFS_IRQ_MASK: mask_nxt = pwdata[1:0];
                ACC_OFS_IRQ_EN: ien_nxt = pwdata[2:0];
                default: ;
            endcase
            if (start_req && warm_r < 13'(ACC_WARMUP_CYC)) begin
                stat_nxt[ACC_IRQ_BIT_EARLY] = 1'b1;
            end
        end
        if (st_r == ACC_CONV && (!ctrl_r[ACC_BIT_ENABLE] || pd_s)) begin
            st_nxt = ACC_IDLE;
            ctrl_nxt[ACC_BIT_START] = 1'b0;
        end
        if (finish) begin
            st_nxt = ACC_IDLE;
            ctrl_nxt[ACC_BIT_START] = 1'b0;
            ctrl_nxt[ACC_BIT_DONE] = 1'b1;
            result_nxt = code_s;
            stat_nxt[ACC_IRQ_BIT_DONE] = 1'b1;
        end
        hold_nxt = st_nxt == ACC_CONV;
        irq_nxt = (ctrl_nxt[ACC_BIT_DONE] && (&ien_nxt)) || |(stat_nxt & mask_nxt);
        pready_nxt = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= ACC_CTRL_RESET;
            result_r <= ACC_RESULT_RESET;
            stat_r <= '0;
            mask_r <= '0;
            ien_r <= '0;
            st_r <= ACC_IDLE;
            warm_r <= '0;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            result_r <= result_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            ien_r <= ien_nxt;
            st_r <= st_nxt;
            warm_r <= warm_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
            hold_r <= hold_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign converter_power_on = ctrl_r[ACC_BIT_ENABLE];
    assign analog_input_selector = ctrl_r[ACC_BIT_CHAN_HI:0];
    assign sample_hold = hold_r;
    assign conv_irq = irq_r;

    property p_done_sets;
        @(posedge pclk) disable iff (!presetn) finish |=> ctrl_r[ACC_BIT_DONE] && !ctrl_r[ACC_BIT_START];
    endproperty
    a_done_sets: assert property (p_done_sets) else $error("completion did not update control");
    property p_result_load;
        @(posedge pclk) disable iff (!presetn) finish |=> result_r == $past(code_s);
    endproperty
    a_result_load: assert property (p_result_load) else $error("result not loaded");
    property p_no_restart;
        @(posedge pclk) disable iff (!presetn) (ctrl_r[ACC_BIT_DONE] || st_r == ACC_CONV) |=> !$rose(st_r == ACC_CONV);
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("conversion restarted while busy");
    property p_pd;
        @(posedge pclk) disable iff (!presetn) pd_s |=> st_r == ACC_IDLE;
    endproperty
    a_pd: assert property (p_pd) else $error("conversion during power-down");
    property p_sel;
        @(posedge pclk) disable iff (!presetn) wr && paddr == ACC_OFS_CTRL
            |=> analog_input_selector == $past(pwdata[ACC_BIT_CHAN_HI:0]);
    endproperty
    a_sel: assert property (p_sel) else $error("channel mismatch");
    property p_irq;
        @(posedge pclk) disable iff (!presetn) (ctrl_r[ACC_BIT_DONE] && &ien_r) |-> conv_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
    property p_zero_start;
        @(posedge pclk) disable iff (!presetn) (wr && paddr == ACC_OFS_CTRL && !pwdata[ACC_BIT_START]
            && st_r == ACC_CONV && ctrl_r[ACC_BIT_ENABLE] && !pd_s && !tim_done) |=> ctrl_r[ACC_BIT_START];
    endproperty
    a_zero_start: assert property (p_zero_start) else $error("software cleared start");
    property p_len;
        @(posedge pclk) disable iff (!presetn) $rose(st_r == ACC_CONV)
            && ctrl_r[ACC_BIT_SPEED_HI:ACC_BIT_SPEED_LO] == 2'b11 && ctrl_r[ACC_BIT_ENABLE]
            |-> ##[269:272] !ctrl_r[ACC_BIT_START];
    endproperty
    a_len: assert property (p_len) else $error("conversion length wrong");
    property p_power;
        @(posedge pclk) disable iff (!presetn) wr && paddr == ACC_OFS_CTRL
            |=> converter_power_on == $past(pwdata[ACC_BIT_ENABLE]);
    endproperty
    a_power: assert property (p_power) else $error("power output wrong");
    c_finish: cover property (@(posedge pclk) disable iff (!presetn) finish);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(conv_irq));
    c_abort: cover property (@(posedge pclk) disable iff (!presetn) st_r == ACC_CONV && !ctrl_r[7]);
endmodule // acc_top

// *** testbench/acc_sar_model.sv ***
// Behavioural analog selector and converter core facing the control block.
`timescale 1ns/10ps
module acc_sar_model (
    input wire logic pclk,
    input wire logic converter_power_on,
    input wire logic [2:0] analog_input_selector,
    output logic [7:0] sar_code
);
    // Pin k sits at k/8 of supply, pin 7 at 255/256, so codes are easy to predict.
    // A core that is switched off has no valid code, so it toggles every cycle.
    initial sar_code = 8'h00;
    always @(posedge pclk) begin
        if (converter_power_on) begin
            sar_code <= (analog_input_selector == 3'h7) ? 8'hFF : {analog_input_selector, 5'h00};
        end else begin
            sar_code <= ~sar_code;
        end
    end
endmodule // acc_sar_model

// *** testbench/acc_top_test.sv ***
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
module acc_top_test;
    import acc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic power_down = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, converter_power_on, sample_hold, conv_irq;
    logic [2:0] analog_input_selector;
    logic [7:0] sar_code;
    logic [32:0] exp_q[$];
    logic [7:0] rnd = 8'h60;
    int err_total = 0;
    int check_count = 0;
    always #10 pclk = ~pclk;
    acc_top acc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sar_code(sar_code), .power_down(power_down), .converter_power_on(converter_power_on),
        .analog_input_selector(analog_input_selector), .sample_hold(sample_hold), .conv_irq(conv_irq));
    acc_sar_model acc_sar_model_inst (.pclk(pclk), .converter_power_on(converter_power_on),
        .analog_input_selector(analog_input_selector), .sar_code(sar_code));
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic fail(input string msg);
        err_total++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        check_count++;
        if (got !== exp) fail(msg);
    endtask
    // Reads are judged at the edge that completes them, against the oldest note.
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            check_count++;
            if (exp_q.size() == 0 || {pslverr, prdata} !== exp_q[0]) fail("read data");
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail("bus timeout");
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
        exp_q.push_back({e, d});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic convert(input logic [1:0] sp, input logic [2:0] ch, input logic ie);
        logic [7:0] c;
        int n;
        int dv;
        c = {1'b1, sp, 2'b00, ch};
        dv = (sp == 2'd0) ? ACC_DIV_0 : (sp == 2'd1) ? ACC_DIV_1 : (sp == 2'd2) ? ACC_DIV_2 : ACC_DIV_3;
        n = 4;
        apb(1'b1, ACC_OFS_CTRL, {24'h0, c | 8'h08});
        apb(1'b1, ACC_OFS_CTRL, {24'h0, c});
        chk({5'h0, analog_input_selector}, {5'h0, ch}, "selector");
        while (sample_hold === 1'b1 && n < 1200) begin
            @(posedge pclk);
            n++;
        end
        chk({7'h0, n >= dv - 1 && n <= dv + 2}, 8'h1, "duration");
        rd(ACC_OFS_CTRL, {24'h0, c | 8'h10}, 1'b0);
        rd(ACC_OFS_RESULT, {24'h0, (ch == 3'h7) ? 8'hFF : {ch, 5'h00}}, 1'b0);
        chk({7'h0, conv_irq}, {7'h0, ie}, "irq set");
        apb(1'b1, ACC_OFS_CTRL, {24'h0, c | 8'h18});
        repeat (3) @(posedge pclk);
        chk({7'h0, sample_hold}, 8'h0, "restart");
        rd(ACC_OFS_CTRL, {24'h0, c | 8'h10}, 1'b0);
        apb(1'b1, ACC_OFS_CTRL, {24'h0, c});
        repeat (2) @(posedge pclk);
        chk({7'h0, conv_irq}, 8'h0, "irq clear");
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ACC_OFS_CTRL, {24'h0, ACC_CTRL_RESET}, 1'b0);
        rd(ACC_OFS_RESULT, {24'h0, ACC_RESULT_RESET}, 1'b0);
        rd(12'h0F0, 32'h0, 1'b1);
        apb(1'b1, ACC_OFS_IRQ_EN, 32'h7);
        apb(1'b1, ACC_OFS_CTRL, 32'h80);
        chk({7'h0, converter_power_on}, 8'h1, "power on");
        // Starting before the warm-up would flag an early start, so honour it.
        repeat (ACC_WARMUP_CYC) @(posedge pclk);
        rnd = lfsr(rnd);
        for (int i = 0; i < 8; i++) begin
            convert(i[1:0], i[2:0] + rnd[2:0], 1'b1);
        end
        apb(1'b1, ACC_OFS_IRQ_EN, 32'h3);
        convert(2'd3, 3'd5, 1'b0);
        apb(1'b1, ACC_OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk({7'h0, conv_irq}, 8'h1, "masked status");
        apb(1'b1, ACC_OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        chk({7'h0, conv_irq}, 8'h0, "status clear");
        rd(ACC_OFS_IRQ_STAT, 32'h0, 1'b0);
        // Power-down in mid-conversion abandons it: start clears and no completion is flagged.
        apb(1'b1, ACC_OFS_CTRL, 32'h88);
        repeat (20) @(posedge pclk);
        chk({7'h0, sample_hold}, 8'h1, "converting");
        power_down <= 1'b1;
        repeat (6) @(posedge pclk);
        chk({7'h0, sample_hold}, 8'h0, "power-down abort");
        rd(ACC_OFS_CTRL, 32'h80, 1'b0);
        apb(1'b1, ACC_OFS_CTRL, 32'h88);
        repeat (3) @(posedge pclk);
        chk({7'h0, sample_hold}, 8'h0, "power-down start");
        rd(ACC_OFS_CTRL, 32'h80, 1'b0);
        power_down <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b1, ACC_OFS_CTRL, 32'h88);
        repeat (10) @(posedge pclk);
        chk({7'h0, sample_hold}, 8'h1, "converting again");
        apb(1'b1, ACC_OFS_CTRL, 32'h08);
        repeat (2) @(posedge pclk);
        chk({7'h0, converter_power_on}, 8'h0, "power off");
        chk({7'h0, sample_hold}, 8'h0, "enable abort");
        rd(ACC_OFS_CTRL, 32'h0, 1'b0);
        rd(ACC_OFS_IRQ_STAT, 32'h0, 1'b0);
        // The converter is already off when the chip goes to sleep, which saves its standby current.
        power_down <= 1'b1;
        complete_run();
    end
endmodule // acc_top_test
